// ===== src/srp_pkg.sv
package srp_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int BITS = 8;
	// byte addresses of the registers
	localparam logic [AW-1:0] CTL_OFS = 8'h00;
	localparam logic [AW-1:0] STAT_OFS = 8'h04;
	localparam logic [AW-1:0] BUF_OFS = 8'h08;
	localparam logic [AW-1:0] PIRQ_OFS = 8'h0c;
	localparam logic [AW-1:0] PMASK_OFS = 8'h10;
	// serial_port_control fields
	localparam int CTL_WRITE_COLLISION_FLAG = 7;
	localparam int CTL_EN = 5;
	localparam int CTL_CKP = 4;
	localparam int CTL_MODE_LO = 0;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [5:0] CTL_WMASK = 6'h3f;
	// serial_port_status fields
	localparam int STAT_SMP = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_BF = 0;
	localparam logic [1:0] STAT_RST = 2'h0;
	// peripheral_irq_flags fields
	localparam int PIRQ_PORT = 3;
	localparam logic [7:0] PIRQ_RST = 8'h00;
	localparam logic [7:0] PMASK_RST = 8'h00;
	// port modes in the low four control bits
	localparam logic [3:0] MODE_M_DIV4 = 4'h0;
	localparam logic [3:0] MODE_M_DIV16 = 4'h1;
	localparam logic [3:0] MODE_M_DIV64 = 4'h2;
	localparam logic [3:0] MODE_M_DIV128 = 4'h3;
	localparam logic [3:0] MODE_S_SEL = 4'h4;
	localparam logic [3:0] MODE_S_NOSEL = 4'h5;
	// serial clock half periods in mclk cycles
	localparam int HALF_W = 7;
	localparam logic [HALF_W-1:0] HALF_DIV4 = 7'h02;
	localparam logic [HALF_W-1:0] HALF_DIV16 = 7'h08;
	localparam logic [HALF_W-1:0] HALF_DIV64 = 7'h20;
	localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;
	localparam logic [4:0] HALVES_PER_BYTE = 5'h10;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD, BUS_RDY} srp_bus_st_t;
endpackage : srp_pkg

// ===== src/srp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module srp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : srp_sync
`default_nettype wire

// ===== src/srp_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module srp_tick_div #(
	parameter int W = 7
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [W-1:0] half_len,
	output logic tick
);
	logic [W-1:0] cnt_q;

	// one-cycle enable every half_len cycles while running
	always_ff @(posedge mclk) begin
		if (!reset_n || !run) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q >= half_len - W'(1)) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
			tick <= 1'b0;
		end
	end
endmodule : srp_tick_div
`default_nettype wire

// ===== src/srp_spi_port.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module srp_spi_port (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [srp_pkg::AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [srp_pkg::DW-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [srp_pkg::DW-1:0] hrdata,
	output logic irq,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_n,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe_n,
	input wire logic ss_n
);
	import srp_pkg::*;

	srp_bus_st_t bus_st_q;
	logic [AW-1:0] addr_q;
	logic acc;
	logic wr_ph;
	logic rd_ph;
	logic [DW-1:0] rd_mux;

	logic [7:0] ctl_q;
	logic [1:0] stat_q;
	logic bf_q;
	logic [7:0] pirq_q;
	logic [7:0] pmask_q;
	logic [BITS-1:0] sr_q;
	logic [BITS-1:0] rxbuf_q;
	logic out_q;
	logic [3:0] bit_cnt_q;

	logic run_q;
	logic sclk_q;
	logic [4:0] half_q;
	logic tick;
	logic [HALF_W-1:0] half_len;

	logic sclk_s;
	logic sclk_d_q;
	logic sdi_s;
	logic ss_n_s;

	logic en;
	logic ckp;
	logic cke;
	logic [3:0] mode;
	logic master;
	logic sel_used;
	logic deselected;
	logic ev_lead;
	logic ev_trail;
	logic ev_sample;
	logic ev_launch;
	logic ev_edge_sample;
	logic samp_q;
	logic byte_done;
	logic busy;
	logic buf_wr;
	logic buf_rd;
	logic write_collision_flag_set;

	assign en = ctl_q[CTL_EN];
	assign ckp = ctl_q[CTL_CKP];
	assign mode = ctl_q[CTL_MODE_LO +: 4];
	assign cke = stat_q[STAT_CKE - 6];
	assign master = (mode[3:2] == 2'b00);
	assign sel_used = (mode == MODE_S_SEL);
	assign deselected = !master && sel_used && ss_n_s;

	// pins from outside the mclk domain
	srp_sync #(.W(3), .INIT(3'b100)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.d({ss_n, sdi, sclk_i}),
		.q({ss_n_s, sdi_s, sclk_s})
	);

	// ---------------- AHB-Lite slave ----------------
	assign acc = hsel && htrans[1] && hready;
	assign wr_ph = (bus_st_q == BUS_WR);
	assign rd_ph = (bus_st_q == BUS_RD);
	assign hreadyout = (bus_st_q != BUS_RD);
	assign hresp = HRESP_OKAY;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bus_st_q <= BUS_IDLE;
			addr_q <= '0;
		end else begin
			unique case (bus_st_q)
				BUS_RD: bus_st_q <= BUS_RDY;
				BUS_IDLE, BUS_WR, BUS_RDY: begin
					if (acc) begin
						bus_st_q <= hwrite ? BUS_WR : BUS_RD;
						addr_q <= haddr;
					end else begin
						bus_st_q <= BUS_IDLE;
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (addr_q)
			CTL_OFS: rd_mux[7:0] = ctl_q;
			STAT_OFS: rd_mux[7:0] = {stat_q, 5'h00, bf_q};
			BUF_OFS: rd_mux[7:0] = rxbuf_q;
			PIRQ_OFS: rd_mux[7:0] = pirq_q;
			PMASK_OFS: rd_mux[7:0] = pmask_q;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hrdata <= '0;
		end else if (rd_ph) begin
			hrdata <= rd_mux;
		end
	end

	assign buf_wr = wr_ph && (addr_q == BUF_OFS);
	assign buf_rd = rd_ph && (addr_q == BUF_OFS);

	// ---------------- configuration ----------------
	assign busy = master ? (run_q || samp_q) : (bit_cnt_q != 4'h0);
	assign write_collision_flag_set = buf_wr && busy;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctl_q <= CTL_RST;
		end else begin
			if (wr_ph && addr_q == CTL_OFS) begin
				ctl_q[5:0] <= hwdata[5:0] & CTL_WMASK;
			end
			// software clears by writing zero; a new collision wins
			if (write_collision_flag_set) begin
				ctl_q[CTL_WRITE_COLLISION_FLAG] <= 1'b1;
			end else if (wr_ph && addr_q == CTL_OFS && !hwdata[CTL_WRITE_COLLISION_FLAG]) begin
				ctl_q[CTL_WRITE_COLLISION_FLAG] <= 1'b0;
			end
			ctl_q[6] <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			stat_q <= STAT_RST;
		end else if (wr_ph && addr_q == STAT_OFS) begin
			stat_q <= hwdata[STAT_SMP:STAT_CKE];
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pmask_q <= PMASK_RST;
		end else if (wr_ph && addr_q == PMASK_OFS) begin
			pmask_q <= hwdata[7:0];
		end
	end

	// ---------------- master clock generator ----------------
	always_comb begin
		unique case (mode[1:0])
			2'b00: half_len = HALF_DIV4;
			2'b01: half_len = HALF_DIV16;
			2'b10: half_len = HALF_DIV64;
			2'b11: half_len = HALF_DIV128;
		endcase
	end

	srp_tick_div #(.W(HALF_W)) u_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(run_q && master),
		.half_len(half_len),
		.tick(tick)
	);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			run_q <= 1'b0;
			half_q <= '0;
		end else if (!en || !master) begin
			run_q <= 1'b0;
			half_q <= '0;
		end else if (buf_wr && !busy) begin
			run_q <= 1'b1;
			half_q <= '0;
		end else if (run_q && tick) begin
			// sixteen half periods give eight whole pulses
			if (half_q == HALVES_PER_BYTE - 5'h01) begin
				run_q <= 1'b0;
				half_q <= '0;
			end else begin
				half_q <= half_q + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sclk_q <= 1'b0;
		end else if (!run_q) begin
			sclk_q <= ckp;
		end else if (tick) begin
			sclk_q <= ~sclk_q;
		end
	end

	// ---------------- edge events ----------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sclk_d_q <= 1'b0;
		end else begin
			sclk_d_q <= sclk_s;
		end
	end

	always_comb begin
		ev_lead = 1'b0;
		ev_trail = 1'b0;
		if (en && master) begin
			ev_lead = run_q && tick && (sclk_q == ckp);
			ev_trail = run_q && tick && (sclk_q != ckp);
		end else if (en && !deselected) begin
			// slave follows the partner's clock
			ev_lead = (sclk_s != sclk_d_q) && (sclk_s != ckp);
			ev_trail = (sclk_s != sclk_d_q) && (sclk_s == ckp);
		end
	end

	// clock edge select: sample on one edge, launch on the other
	assign ev_edge_sample = cke ? ev_lead : ev_trail;
	assign ev_sample = master ? samp_q : ev_edge_sample;
	assign ev_launch = cke ? ev_trail : ev_lead;

	// master samples a cycle after its own edge, once synchronised data has caught up
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			samp_q <= 1'b0;
		end else begin
			samp_q <= master && ev_edge_sample;
		end
	end
	assign byte_done = ev_sample && (bit_cnt_q == 4'(BITS - 1));

	// ---------------- shift engine ----------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sr_q <= '0;
		end else if (buf_wr && !busy) begin
			sr_q <= hwdata[BITS-1:0];
		end else if (ev_sample) begin
			sr_q <= {sr_q[BITS-2:0], sdi_s};
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			out_q <= 1'b0;
		end else if (buf_wr && !busy) begin
			out_q <= hwdata[BITS-1];
		end else if (ev_launch) begin
			out_q <= sr_q[BITS-1];
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bit_cnt_q <= '0;
		end else if (!en || deselected) begin
			bit_cnt_q <= '0;
		end else if (byte_done) begin
			bit_cnt_q <= '0;
		end else if (ev_sample) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// separate receive buffer
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rxbuf_q <= '0;
		end else if (byte_done) begin
			rxbuf_q <= {sr_q[BITS-2:0], sdi_s};
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bf_q <= 1'b0;
		end else if (byte_done) begin
			bf_q <= 1'b1;
		end else if (buf_rd) begin
			bf_q <= 1'b0;
		end
	end

	// ---------------- interrupts ----------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pirq_q <= PIRQ_RST;
		end else begin
			if (rd_ph && addr_q == PIRQ_OFS) begin
				pirq_q <= PIRQ_RST;
			end
			if (byte_done) begin
				pirq_q[PIRQ_PORT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(pirq_q & pmask_q);
		end
	end

	// ---------------- pins ----------------
	assign sclk_o = sclk_q;
	assign sclk_oe_n = !(en && master);
	assign sdo_o = out_q;
	assign sdo_oe_n = !en || deselected;
endmodule : srp_spi_port
`default_nettype wire

// ===== dv/srp_spi_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module srp_spi_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [srp_pkg::AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [srp_pkg::DW-1:0] hrdata,
	input wire logic irq,
	input wire logic sclk_o,
	input wire logic sclk_oe_n,
	input wire logic sdo_oe_n
);
	import srp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic tk;
	logic p_q;
	logic [4:0] tog_q;
	logic [7:0] qt_q;
	assign tk = hsel && htrans[1] && hready;
	// toggles of one frame, closed after a long quiet spell
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			p_q <= 1'b0;
			tog_q <= 5'h00;
			qt_q <= 8'h96;
		end else begin
			p_q <= sclk_o;
			if (sclk_oe_n) begin
				tog_q <= 5'h00;
				qt_q <= 8'h96;
			end else if (sclk_o != p_q) begin
				tog_q <= tog_q + 5'h01;
				qt_q <= 8'h00;
			end else if (qt_q != 8'h96) begin
				qt_q <= qt_q + 8'h01;
			end else begin
				tog_q <= 5'h00;
			end
		end
	end
	rd_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	wr_nowait_a: assert property (tk && hwrite |=> hreadyout)
		else $error("write stalled");
	irq_clear_a: assert property (tk && !hwrite && haddr == PIRQ_OFS |-> ##4 !irq)
		else $error("irq not cleared by flag read");
	mst_drive_a: assert property (!sclk_oe_n |-> !sdo_oe_n)
		else $error("master not driving data out");
	half_per_a: assert property (!sclk_oe_n && $changed(sclk_o) |=> $stable(sclk_o))
		else $error("clock half period too short");
	pulse_cnt_a: assert property (qt_q == 8'h95 |-> tog_q == 5'h10)
		else $error("clock pulse count wrong");
	resp_okay_a: assert property (hresp == HRESP_OKAY)
		else $error("error response");
	hi_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
endmodule : srp_spi_monitor
bind srp_spi_port srp_spi_monitor u_srp_spi_monitor (.mclk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq, .sclk_o, .sclk_oe_n, .sdo_oe_n);
`default_nettype wire

// ===== dv/srp_spi_partner.sv
`timescale 1ns/1ps
`default_nettype none
module srp_spi_partner (
	input wire logic sclk,
	input wire logic sdo,
	input wire logic [7:0] tx,
	output logic sdi,
	output logic [7:0] rx
);
	int pc = 0;
	int n = 0;
	initial rx = 8'h00;
	// sample on idle->active, msb first
	always @(posedge sclk) begin
		rx <= {rx[6:0], sdo};
		pc <= (pc + 1) % 8;
	end
	// next bit on active->idle; a settling clock after reset moves nothing
	always @(negedge sclk) n <= pc;
	assign sdi = tx[7 - n];
endmodule : srp_spi_partner
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
	import srp_pkg::*;
	logic mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, ss_n = 1, s_sck = 0, s_sdi = 0;
	logic [7:0] haddr = 8'h00, p_tx = 8'h00, p_rx;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, irq, sclk_o, sclk_oe_n, sdo_o, sdo_oe_n, p_sdi;
	wire logic sck = sclk_oe_n ? s_sck : sclk_o;
	wire logic sdi = sclk_oe_n ? s_sdi : p_sdi;
	int n_errors = 0, check_count = 0, cyc = 0;
	always #4 mclk = ~mclk;
	srp_spi_port u_srp_spi_port (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
		.sclk_i(sck), .sclk_o, .sclk_oe_n, .sdi, .sdo_o, .sdo_oe_n, .ss_n);
	srp_spi_partner u_srp_spi_partner (.sclk(sclk_o), .sdo(sdo_o), .tx(p_tx), .sdi(p_sdi),
		.rx(p_rx));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'h0, d});
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK(rd[7:0], e)
	endtask : rdchk
	task automatic t_regs();
		logic [7:0] a[5] = '{CTL_OFS, STAT_OFS, PIRQ_OFS, PMASK_OFS, 8'h14};
		wr(8'h14, 8'hff);
		foreach (a[i]) rdchk(a[i], 8'h00);
		$display("register reset test done");
	endtask : t_regs
	task automatic t_master();
		for (int m = 0; m < 4; m++) begin
			wr(CTL_OFS, 8'h20 | 8'(m));
			wr(STAT_OFS, 8'h40);
			wr(PMASK_OFS, 8'h08);
			p_tx = 8'h3c ^ 8'(m);
			wr(BUF_OFS, 8'ha5 + 8'(m));
			wr(BUF_OFS, 8'h11);
			rdchk(CTL_OFS, 8'ha0 | 8'(m));
			while (irq !== 1'b1) @(posedge mclk);
			`CHK(p_rx, 8'ha5 + 8'(m))
			rdchk(STAT_OFS, 8'h41);
			rdchk(PIRQ_OFS, 8'h08);
			repeat (3) @(posedge mclk);
			`CHK(irq, 1'b0)
			rdchk(CTL_OFS, 8'ha0 | 8'(m));
			rdchk(BUF_OFS, 8'h3c ^ 8'(m));
			rdchk(STAT_OFS, 8'h40);
			wr(CTL_OFS, 8'h20 | 8'(m));
			rdchk(CTL_OFS, 8'h20 | 8'(m));
			// quiet gap lets the monitor close its pulse count
			repeat (160) @(posedge mclk);
		end
		$display("master test done");
	endtask : t_master
	task automatic t_slave();
		logic [7:0] got = 8'h00;
		logic [7:0] sb = 8'h5b;
		wr(PMASK_OFS, 8'h00);
		wr(CTL_OFS, 8'h24);
		ss_n <= 1'b0;
		wr(BUF_OFS, 8'h96);
		// link clock of 125 ns, data changes while it is low
		for (int i = 7; i >= 0; i--) begin
			s_sdi <= sb[i];
			#62.5 s_sck <= 1'b1;
			got = {got[6:0], sdo_o};
			#62.5 s_sck <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		`CHK(got, 8'h96)
		`CHK(irq, 1'b0)
		rdchk(PIRQ_OFS, 8'h08);
		rdchk(BUF_OFS, 8'h5b);
		ss_n <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK(sdo_oe_n, 1'b1)
		repeat (16) #62.5 s_sck <= ~s_sck;
		repeat (8) @(posedge mclk);
		rdchk(STAT_OFS, 8'h40);
		$display("slave test done");
	endtask : t_slave
	task automatic t_nosel();
		logic [7:0] got = 8'h00;
		logic [7:0] sb = 8'ha6;
		s_sck <= 1'b1;
		wr(STAT_OFS, 8'h00);
		wr(CTL_OFS, 8'h35);
		wr(BUF_OFS, 8'hc3);
		`CHK(sdo_oe_n, 1'b0)
		// high idle clock, data changes as it leaves idle
		for (int i = 7; i >= 0; i--) begin
			#62.5 s_sck <= 1'b0;
			s_sdi <= sb[i];
			#62.5 s_sck <= 1'b1;
			got = {got[6:0], sdo_o};
		end
		repeat (8) @(posedge mclk);
		`CHK(got, 8'hc3)
		rdchk(STAT_OFS, 8'h01);
		rdchk(BUF_OFS, 8'ha6);
		$display("slave without select test done");
	endtask : t_nosel
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_master();
		t_slave();
		t_nosel();
		summarize();
	end
endmodule : tb
`default_nettype wire
